// *** rtl/spa_regs.vh ***
// register offsets, field masks and reset values of the six-bit port
`ifndef SPA_REGS_VH
`define SPA_REGS_VH
`define SPA_OFF_PIN_LEVEL_PORT 8'h00
`define SPA_OFF_PIN_DIRECTION 8'h04
`define SPA_OFF_OUTPUT_LATCH 8'h08
`define SPA_OFF_ANALOG_SELECT 8'h0c
`define SPA_OFF_PULLUP_ENABLE 8'h10
`define SPA_OFF_OPEN_DRAIN_ENABLE 8'h14
`define SPA_OFF_SLEW_LIMIT_ENABLE 8'h18
`define SPA_OFF_INPUT_THRESHOLD_SELECT 8'h1c
`define SPA_OFF_PORT_CONFIG 8'h20
`define SPA_MASK_ALL 6'h3f
`define SPA_MASK_NO3 6'h37
`define SPA_MASK_ANALOG_SELECT_BIT 6'h17
`define SPA_PIN3_BIT 6'h08
`define SPA_PIN3_IDX 3
`define SPA_RST_DIRECTION 6'h3f
`define SPA_RST_LATCH 6'h00
`define SPA_RST_ANALOG_SELECT_BIT 6'h17
`define SPA_RST_PULLUP 6'h3f
`define SPA_RST_OPEN_DRAIN 6'h00
`define SPA_RST_SLEW 6'h37
`define SPA_RST_THRESHOLD 6'h3f
`define SPA_RST_CONFIG 2'h0
`define SPA_CFG_PUDIS_BIT 0
`define SPA_CFG_MASTER_CLEAR_ENABLE_BIT 1
`define SPA_HTRANS_NONSEQ 2'h2
`define SPA_HSIZE_WORD 3'h2
`endif

// *** rtl/spa_sync.v ***
// two-flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module spa_sync #(
  parameter WIDTH = 6
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // data
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // spa_sync

// *** rtl/spa_pin_cell.v ***
// per-pin drive, pull-up and input path of the port
`timescale 1ns/1ps
module spa_pin_cell (
  // configuration
  input wire dir_in,
  input wire latch_val,
  input wire analog_sel,
  input wire pullup_bit,
  input wire pullup_force,
  input wire global_pud,
  input wire open_drain,
  input wire st_sel,
  // pin side
  input wire pad_st,
  input wire pad_ttl,
  output wire pad_out,
  output wire pad_oe,
  output wire pad_pullup,
  output wire pad_ibuf_en,
  output wire raw_in
);
  // open drain only ever drives low; high level comes from the board
  assign pad_out = latch_val;
  assign pad_oe = ~dir_in & ~(open_drain & latch_val);
  // pull-up dropped while the pin is an output
  assign pad_pullup = dir_in & ((pullup_bit & ~global_pud) | pullup_force);
  assign pad_ibuf_en = ~analog_sel;
  assign raw_in = (st_sel ? pad_st : pad_ttl) & ~analog_sel;
endmodule // spa_pin_cell

// *** rtl/spa_port.v ***
// six-bit general-purpose port with ahb-lite register slave
// How it works
// - slew bit set limits pin edge rate
// - per-pin threshold governs reads and change detect
// - threshold 1 selects schmitt, resets to one
// - analog pin reads zero, input buffer off
// - analog select leaves digital output driving
// - analog bits reset to analog mode
// - analog bits exist for pins 4,2,1,0
// - direction one is input, zero output
// - pin three direction bit reads one
// - port read gives pins, write hits latch
// - latch read returns latch contents
// - unimplemented bits read as zero
// - pull-up on when bit set, global clear
// - pull-up off while pin is output
// - master clear forces pin three pull-up
// - open-drain bit makes output sink-only
// - pins are inputs after reset, output latch zero
// - analog functions connect only when selected
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "spa_regs.vh"
module spa_port #(
  parameter PINS = 6
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // pins, seen through the schmitt and ttl receivers
  input wire [PINS-1:0] pad_st_in,
  input wire [PINS-1:0] pad_ttl_in,
  output reg [PINS-1:0] pad_out,
  output reg [PINS-1:0] pad_oe,
  output reg [PINS-1:0] pad_pullup_en,
  output reg [PINS-1:0] pad_slew_limit,
  output reg [PINS-1:0] pad_ibuf_en,
  output reg [PINS-1:0] analog_connect,
  // synchronised levels after threshold select for change detect
  output reg [PINS-1:0] pin_level_sync
);
  reg [PINS-1:0] pin_direction_reg;
  reg [PINS-1:0] output_latch_reg;
  reg [PINS-1:0] analog_select_reg;
  reg [PINS-1:0] pullup_enable_reg;
  reg [PINS-1:0] open_drain_enable_reg;
  reg [PINS-1:0] slew_limit_enable_reg;
  reg [PINS-1:0] input_threshold_select_reg;
  reg [1:0] port_config_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [31:0] rdata_next;
  wire [PINS-1:0] raw_in;
  wire [PINS-1:0] sync_in;
  wire [PINS-1:0] cell_out;
  wire [PINS-1:0] cell_oe;
  wire [PINS-1:0] cell_pu;
  wire [PINS-1:0] cell_ibuf;
  wire global_pullup_disable;
  wire master_clear_enable;
  wire addr_phase;

  assign global_pullup_disable = port_config_reg[`SPA_CFG_PUDIS_BIT];
  assign master_clear_enable = port_config_reg[`SPA_CFG_MASTER_CLEAR_ENABLE_BIT];
  assign addr_phase = hsel & hready & htrans[1];

  // read view of each register, bits 7-6 and holes give zero
  function [31:0] read_mux;
    input [7:0] a;
    input [PINS-1:0] lvl;
    begin
      case (a)
        `SPA_OFF_PIN_LEVEL_PORT: read_mux = {26'h0, lvl};
        `SPA_OFF_PIN_DIRECTION:
          read_mux = {26'h0, pin_direction_reg | `SPA_PIN3_BIT};
        `SPA_OFF_OUTPUT_LATCH: read_mux = {26'h0, output_latch_reg};
        `SPA_OFF_ANALOG_SELECT: read_mux = {26'h0, analog_select_reg};
        `SPA_OFF_PULLUP_ENABLE: read_mux = {26'h0, pullup_enable_reg};
        `SPA_OFF_OPEN_DRAIN_ENABLE:
          read_mux = {26'h0, open_drain_enable_reg};
        `SPA_OFF_SLEW_LIMIT_ENABLE:
          read_mux = {26'h0, slew_limit_enable_reg};
        `SPA_OFF_INPUT_THRESHOLD_SELECT:
          read_mux = {26'h0, input_threshold_select_reg};
        `SPA_OFF_PORT_CONFIG: read_mux = {30'h0, port_config_reg};
        default: read_mux = 32'h0;
      endcase
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      spa_pin_cell u_cell (
        .dir_in(pin_direction_reg[i]),
        .latch_val(output_latch_reg[i]),
        .analog_sel(analog_select_reg[i]),
        .pullup_bit(pullup_enable_reg[i]),
        .pullup_force(master_clear_enable & (i == `SPA_PIN3_IDX)),
        .global_pud(global_pullup_disable),
        .open_drain(open_drain_enable_reg[i]),
        .st_sel(input_threshold_select_reg[i]),
        .pad_st(pad_st_in[i]),
        .pad_ttl(pad_ttl_in[i]),
        .pad_out(cell_out[i]),
        .pad_oe(cell_oe[i]),
        .pad_pullup(cell_pu[i]),
        .pad_ibuf_en(cell_ibuf[i]),
        .raw_in(raw_in[i])
      );
    end
  endgenerate

  spa_sync #(.WIDTH(PINS)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(raw_in),
    .q(sync_in)
  );

  always @* begin
    rdata_next = read_mux(haddr, sync_in);
  end

  // bus: write data arrives one cycle after its address, zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end

  // register writes; only implemented bits can be stored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_direction_reg <= `SPA_RST_DIRECTION;
      output_latch_reg <= `SPA_RST_LATCH;
      analog_select_reg <= `SPA_RST_ANALOG_SELECT_BIT;
      pullup_enable_reg <= `SPA_RST_PULLUP;
      open_drain_enable_reg <= `SPA_RST_OPEN_DRAIN;
      slew_limit_enable_reg <= `SPA_RST_SLEW;
      input_threshold_select_reg <= `SPA_RST_THRESHOLD;
      port_config_reg <= `SPA_RST_CONFIG;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        `SPA_OFF_PIN_LEVEL_PORT,
        `SPA_OFF_OUTPUT_LATCH:
          output_latch_reg <= hwdata[PINS-1:0];
        `SPA_OFF_PIN_DIRECTION:
          pin_direction_reg <= (hwdata[PINS-1:0] & `SPA_MASK_NO3)
            | `SPA_PIN3_BIT;
        `SPA_OFF_ANALOG_SELECT:
          analog_select_reg <= hwdata[PINS-1:0] & `SPA_MASK_ANALOG_SELECT_BIT;
        `SPA_OFF_PULLUP_ENABLE:
          pullup_enable_reg <= hwdata[PINS-1:0] & `SPA_MASK_ALL;
        `SPA_OFF_OPEN_DRAIN_ENABLE:
          open_drain_enable_reg <= hwdata[PINS-1:0] & `SPA_MASK_NO3;
        `SPA_OFF_SLEW_LIMIT_ENABLE:
          slew_limit_enable_reg <= hwdata[PINS-1:0] & `SPA_MASK_NO3;
        `SPA_OFF_INPUT_THRESHOLD_SELECT:
          // a change can glitch peripherals; software's job to avoid
          input_threshold_select_reg <= hwdata[PINS-1:0];
        `SPA_OFF_PORT_CONFIG:
          port_config_reg <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // pin outputs, registered so every top output comes from a flip-flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= {PINS{1'b0}};
      pad_oe <= {PINS{1'b0}};
      pad_pullup_en <= {PINS{1'b0}};
      pad_slew_limit <= {PINS{1'b0}};
      pad_ibuf_en <= {PINS{1'b0}};
      analog_connect <= {PINS{1'b0}};
      pin_level_sync <= {PINS{1'b0}};
    end else begin
      pad_out <= cell_out;
      pad_oe <= cell_oe & `SPA_MASK_NO3;
      pad_pullup_en <= cell_pu;
      pad_slew_limit <= slew_limit_enable_reg;
      pad_ibuf_en <= cell_ibuf;
      analog_connect <= analog_select_reg;
      pin_level_sync <= sync_in;
    end
  end
endmodule // spa_port

// *** dv/spa_board.sv ***
// board model: drives or senses each pin of the port
`timescale 1ns/1ps
module spa_board (
  // clock
  input logic hclk,
  // from the port
  input logic [5:0] pad_out,
  input logic [5:0] pad_oe,
  input logic [5:0] pad_pullup_en,
  // from the bench
  input logic [5:0] ext_val,
  input logic [5:0] ext_en,
  input logic [5:0] skew,
  // receivers
  output logic [5:0] pad_st_in,
  output logic [5:0] pad_ttl_in
);
  logic tgl = 1'b0;
  // a floating pin wanders, so nothing may lean on a stale level
  always @(posedge hclk) tgl <= ~tgl;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_oe[i]) pad_st_in[i] = pad_out[i];
      else if (ext_en[i]) pad_st_in[i] = ext_val[i];
      else if (pad_pullup_en[i]) pad_st_in[i] = 1'b1;
      else pad_st_in[i] = tgl;
    end
  end
  // skew lets the two receivers disagree
  assign pad_ttl_in = pad_st_in ^ skew;
endmodule // spa_board

// *** dv/spa_port_props.sv ***
// assertions on the bus and pin outputs of the port
`timescale 1ns/1ps
module spa_port_props (
  // bus
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [7:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  // pins
  input logic [5:0] pad_st_in,
  input logic [5:0] pad_ttl_in,
  input logic [5:0] pad_oe,
  input logic [5:0] pad_pullup_en,
  input logic [5:0] pad_slew_limit,
  input logic [5:0] pad_ibuf_en,
  input logic [5:0] analog_connect,
  input logic [5:0] pin_level_sync
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_reg;
  logic [7:0] a_reg;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) rd_reg <= 1'b0;
    else rd_reg <= hsel && hready && htrans[1] && !hwrite;
  always @(posedge hclk) a_reg <= haddr;
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_pin3_undriven: assert property (!pad_oe[3])
    else $error("pin 3 driven");
  a_pullup_output: assert property ((pad_pullup_en & pad_oe) == 6'h00)
    else $error("pull-up on a driven pin");
  // outputs show reset zeros until the first edge after release
  a_analog_link: assert property ($past(hresetn) |->
    analog_connect == ~pad_ibuf_en)
    else $error("analog connect and input buffer disagree");
  a_analog_bits: assert property ((analog_connect & 6'h28) == 6'h00)
    else $error("analog on a pin without select");
  a_slew_bits: assert property (!pad_slew_limit[3])
    else $error("slew limit on pin 3");
  a_upper_zero: assert property (rd_reg |-> hrdata[31:6] == 26'h0)
    else $error("upper read bits not zero");
  a_dir3_one: assert property (rd_reg && a_reg == 8'h04 |-> hrdata[3])
    else $error("direction bit 3 reads zero");
  a_sync_lag: assert property ($rose(pin_level_sync[0]) |->
    $past(pad_st_in[0], 3) || $past(pad_ttl_in[0], 3))
    else $error("synchronised level rose too early");
endmodule // spa_port_props
bind spa_port spa_port_props u_props (.*);

// *** dv/tb.sv ***
// self-checking bench for the six-bit port
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] skew = 6'h00;
  wire [31:0] hrdata;
  wire hreadyout;
  wire [5:0] st, ttl, po, oe, pu, slew, ibuf, acon;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [7:0] adr [9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
    8'h1c, 8'h20, 8'h24};
  logic [5:0] rst_v [9] = '{6'h3f, 0, 6'h17, 6'h3f, 0, 6'h37, 6'h3f, 0, 0};
  logic [5:0] one_v [9] = '{6'h3f, 6'h3f, 6'h17, 6'h3f, 6'h37, 6'h37,
    6'h3f, 6'h03, 0};
  logic [5:0] zero_v [9] = '{6'h08, 0, 0, 0, 0, 0, 0, 0, 0};
  spa_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .pad_st_in(st), .pad_ttl_in(ttl),
    .pad_out(po), .pad_oe(oe), .pad_pullup_en(pu), .pad_slew_limit(slew),
    .pad_ibuf_en(ibuf), .analog_connect(acon), .pin_level_sync());
  spa_board board (.hclk(hclk), .pad_out(po), .pad_oe(oe),
    .pad_pullup_en(pu), .ext_val(ext_val), .ext_en(ext_en), .skew(skew),
    .pad_st_in(st), .pad_ttl_in(ttl));
  initial forever #5 hclk = ~hclk;
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits settle the sync stages and pad registers before any compare
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    repeat (4) @(posedge hclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 9; i++) rd(adr[i], 32'(rst_v[i]));
    $display("test reset values done");
    for (int i = 0; i < 9; i++) xfer(adr[i], 1'b1, 32'hffffffff);
    for (int i = 0; i < 9; i++) rd(adr[i], 32'(one_v[i]));
    for (int i = 0; i < 9; i++) xfer(adr[i], 1'b1, 32'h0);
    for (int i = 0; i < 9; i++) rd(adr[i], 32'(zero_v[i]));
    chk(32'(oe), 32'h37);
    chk(32'(pu), 32'h0);
    $display("test register access done");
    ext_en <= 6'h08;
    ext_val <= 6'h08;
    xfer(8'h08, 1'b1, 32'h2a);
    chk(32'(po), 32'h2a);
    rd(8'h00, 32'h2a);
    xfer(8'h00, 1'b1, 32'h15);
    rd(8'h08, 32'h15);
    xfer(8'h0c, 1'b1, 32'h17);
    chk(32'(po), 32'h15);
    chk(32'(ibuf), 32'h28);
    rd(8'h00, 32'h08);
    $display("test latch and analog done");
    xfer(8'h0c, 1'b1, 32'h0);
    xfer(8'h04, 1'b1, 32'h3f);
    ext_en <= 6'h3f;
    ext_val <= 6'h2d;
    skew <= 6'h3f;
    xfer(8'h1c, 1'b1, 32'h3f);
    rd(8'h00, 32'h2d);
    xfer(8'h1c, 1'b1, 32'h0);
    rd(8'h00, 32'h12);
    $display("test threshold done");
    ext_en <= 6'h00;
    xfer(8'h10, 1'b1, 32'h3f);
    chk(32'(pu), 32'h3f);
    xfer(8'h20, 1'b1, 32'h1);
    chk(32'(pu), 32'h0);
    xfer(8'h20, 1'b1, 32'h3);
    xfer(8'h10, 1'b1, 32'h0);
    chk(32'(pu), 32'h08);
    rd(8'h10, 32'h0);
    $display("test pull-up done");
    xfer(8'h04, 1'b1, 32'h0);
    xfer(8'h08, 1'b1, 32'h01);
    xfer(8'h14, 1'b1, 32'h37);
    chk(32'(oe), 32'h36);
    xfer(8'h18, 1'b1, 32'h05);
    chk(32'(slew), 32'h05);
    $display("test drive done");
    conclude;
  end
endmodule // tb
